// ---- rtl/irq_accept_pkg.sv ----
// Constants, types and fixed tables of the interrupt acceptance block.
// Assumes a single system clock; one CPU state equals one clock cycle.
package irq_accept_pkg;

  // Source counts
  localparam int NCPU = 9;
  localparam int NPER = 21;
  localparam int NPIN = 4;
  localparam int NSRC = NCPU + NPER + NPIN;
  localparam int NNMI = 11;              // Indices below this are non-maskable
  localparam int NMSK = NSRC - NNMI;
  localparam int NCH  = 4;

  // Levels and mask
  localparam logic [2:0] LVL_OFF  = 3'h0;
  localparam logic [2:0] LVL_TOP  = 3'h7;
  localparam logic [2:0] LVL_ONE  = 3'h1;
  localparam int         MASK_LSB = 12;  // Mask field inside the status word

  // Vector area and acceptance timing, in CPU states
  localparam logic [23:0] VEC_BASE   = 24'hffff00;
  localparam logic [23:0] VEC_AREA   = 24'h000100;
  localparam int          ACC_STATES = 18;
  localparam logic [4:0]  SEQ_PUSH_PC = 5'h02;
  localparam logic [4:0]  SEQ_PUSH_SR = 5'h06;
  localparam logic [4:0]  SEQ_MASK    = 5'h0a;
  localparam logic [4:0]  SEQ_LAST    = 5'(ACC_STATES - 2);
  localparam logic [23:0] PC_SLOT     = 24'h000004;
  localparam logic [23:0] SR_SLOT     = 24'h000006;
  localparam logic [7:0]  NEST_ONE    = 8'h01;
  localparam logic [7:0]  START_OFF   = 8'h00;

  // Fixed vectors, index order equals default priority
  localparam logic [7:0] VEC_TAB [NSRC] = '{
    8'h00, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
    8'h20, 8'h24, 8'h28, 8'h3c, 8'h40,
    8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h6c, 8'h70, 8'h7c,
    8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c,
    8'ha0, 8'ha4, 8'ha8, 8'hac};

  // Where peripheral and pin requests land in the source index
  localparam int PER_IDX [NPER] = '{10, 14, 15, 16, 17, 18, 19, 20, 21, 22,
                                    23, 24, 25, 26, 27, 28, 29, 30, 31, 32, 33};
  localparam int PIN_IDX [NPIN] = '{9, 11, 12, 13};

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SEQ   = 3'b010,
    ST_FIRST = 3'b100
  } seq_e;

  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [7:0] vector;
    logic [5:0] src;
  } present_s;

  typedef struct packed {
    logic        we;
    logic [23:0] addr;
    logic [31:0] data;
  } stack_wr_s;

  // Transfer size: 0 one byte, 1 two bytes, 2 four bytes
  typedef struct packed {
    logic       go;
    logic [1:0] channel;
    logic [1:0] size;
  } dma_s;

endpackage

// ---- rtl/irq_accept.sv ----
// Interrupt prioritisation and acceptance sequencer beside the CPU core.
// Assumes the core pulses instr_boundary at the end of each instruction
// and owns the stack pointer, adjusting it after the two pushes.
//
// Notes on behaviour
// (RL1) Handles 34 sources: 9 CPU, 21 internal peripheral, 4 external pin.
// (RL2) Each source owns a fixed, non-programmable vector.
// (RL3) Each maskable source has a programmable level from six levels.
// (RL4) Non-maskable sources are always level 7 and cannot be disabled.
// (RL5) Only the highest-level pending request is presented to the core.
// (RL6) Accept when level is at least the mask, else keep it pending.
// (RL7) Set-mask loads its operand into the mask, valid from next instruction.
// (RL8) Mask-all sets the mask to 7, blocking every maskable level.
// (RL9) Equal levels resolve by default priority, smaller vector wins.
// (RL10) Reading the vector supplies it and clears that pending request.
// (RL11) Acceptance pushes program counter and status word at the stack pointer.
// (RL12) Acceptance loads mask with level plus one, level 7 stays 7.
// (RL13) Acceptance increments the nesting count by one.
// (RL14) Handler address is fetched from vector base plus vector.
// (RL15) Whole acceptance sequence takes 18 states.
// (RL16) Return pops program counter and status word, decrements nesting count.
// (RL17) New requests are not sampled until the handler's first instruction ends.
// (RL18) Reset sets the mask to 7.
// (RL19) Vector table spans 256 bytes from the vector base.
// (RL20) An accepted request or software may start a 1, 2 or 4 byte transfer.
// (RL21) Pending flags hold until their vector is read or a transfer starts from them, so masked requests stay.
`timescale 1ns/1ps

module irq_accept
  import irq_accept_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  // Request sources
  input  wire logic [NCPU-1:0]       cpu_req,
  input  wire logic [NPER-1:0]       periph_req,
  input  wire logic [NPIN-1:0]       pin_req,
  // Priority levels of maskable sources
  input  wire logic [NMSK-1:0][2:0]  level_cfg,
  // Core instruction events
  input  wire logic                  instr_boundary,
  input  wire logic                  set_mask_instruction,
  input  wire logic                  mask_all_instruction,
  input  wire logic [2:0]            mask_operand,
  input  wire logic                  return_from_handler,
  input  wire logic [15:0]           popped_status,
  // Core context
  input  wire logic [23:0]           system_stack_pointer,
  input  wire logic [31:0]           core_pc,
  input  wire logic [15:0]           status_word,
  // Direct transfer setup
  input  wire logic [NCH-1:0][7:0]   dma_start_vector,
  input  wire logic [NCH-1:0][1:0]   dma_size_cfg,
  input  wire logic [NCH-1:0]        dma_soft_start,
  // Presentation and state
  output present_s                   present,
  output logic [2:0]                 interrupt_mask_level,
  output logic [7:0]                 nesting_count,
  output logic                       accept_busy,
  // Sequence outputs
  output stack_wr_s                  stack_wr,
  output logic                       handler_fetch,
  output logic [23:0]                handler_addr,
  output dma_s                       dma_go
);

  seq_e              state_reg;
  logic [4:0]        cnt_reg;
  logic [NSRC-1:0]   pend_reg;
  logic [NSRC-1:0]   pend_next;
  logic [NSRC-1:0]   set_vec;
  logic [NSRC-1:0]   clr_vec;
  logic [NCH-1:0]    soft_reg;
  logic [NPIN-1:0]   pin_s1_reg;
  logic [NPIN-1:0]   pin_s2_reg;
  logic [NPIN-1:0]   pin_s3_reg;
  logic [2:0]        mask_reg;
  logic [2:0]        mask_now;
  logic [7:0]        nest_reg;
  logic [2:0]        cur_lvl_reg;
  logic [7:0]        cur_vec_reg;
  present_s          pres_reg;
  present_s          best;
  logic [2:0]        lvl;
  logic              dma_hit;
  logic              dma_soft;
  logic [1:0]        dma_ch;
  logic [5:0]        dma_src;
  logic              can_take;
  logic              pres_live;
  logic              take_top;
  logic              take_dma;
  logic              take_irq;
  logic              busy_reg;
  stack_wr_s         stack_reg;
  logic              fetch_reg;
  logic [23:0]       haddr_reg;
  dma_s              dma_reg;

  // Level a source carries; configured 7 is not a maskable level
  function automatic logic [2:0] src_level(input int i);
    logic [2:0] l;
    if (i < NNMI)
      l = LVL_TOP;                                                  // RL4
    else
      l = level_cfg[i-NNMI];                                        // RL3
    if (i >= NNMI && l == LVL_TOP)
      l = LVL_OFF;
    return l;
  endfunction

  // Status word with the mask field replaced
  function automatic logic [15:0] with_mask(input logic [15:0] sw, input logic [2:0] m);
    logic [15:0] r;
    r = sw;
    r[MASK_LSB +: 3] = m;
    return r;
  endfunction

  // Pin synchroniser; third stage only serves the edge detector
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= pin_req;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Map every source into the fixed index order
  always_comb begin
    set_vec = '0;
    set_vec[NCPU-1:0] = cpu_req;                                    // RL1
    for (int k = 0; k < NPER; k++)
      set_vec[PER_IDX[k]] = periph_req[k];                          // RL1
    for (int k = 0; k < NPIN; k++)
      set_vec[PIN_IDX[k]] = pin_s2_reg[k] & ~pin_s3_reg[k];         // RL1
  end

  // Pick the highest level; strict compare keeps the smaller index on ties
  always_comb begin
    best = '0;
    lvl  = LVL_OFF;
    for (int i = 0; i < NSRC; i++) begin
      lvl = src_level(i);
      if (pend_reg[i] && lvl > best.level) begin                    // RL5
        best.valid  = 1'b1;
        best.level  = lvl;
        best.vector = VEC_TAB[i];                                   // RL2
        best.src    = 6'(i);                                        // RL9
      end
    end
  end

  // Presentation register toward the core
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      pres_reg <= '0;
    else
      pres_reg <= best;                                             // RL5
  end

  // Transfer candidates; lowest channel wins, soft start first in a channel
  always_comb begin
    dma_hit  = 1'b0;
    dma_soft = 1'b0;
    dma_ch   = '0;
    dma_src  = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (soft_reg[c]) begin
        dma_hit  = 1'b1;
        dma_soft = 1'b1;
        dma_ch   = 2'(c);
      end else begin
        for (int s = NSRC - 1; s >= NNMI; s--) begin
          if (dma_start_vector[c] != START_OFF && pend_reg[s] &&
              dma_start_vector[c] == {2'h0, VEC_TAB[s][7:2]}) begin   // RL20
            dma_hit  = 1'b1;
            dma_soft = 1'b0;
            dma_ch   = 2'(c);
            dma_src  = 6'(s);
          end
        end
      end
    end
  end

  // Mask as seen by the next decision, so a mask write counts at once
  always_comb begin
    if (mask_all_instruction)
      mask_now = LVL_TOP;                                           // RL8
    else if (set_mask_instruction)
      mask_now = mask_operand;                                      // RL7
    else
      mask_now = mask_reg;
  end

  // Acceptance decision at an instruction boundary while idle
  always_comb begin
    can_take  = (state_reg == ST_IDLE) && instr_boundary;           // RL17
    pres_live = pres_reg.valid && pend_reg[pres_reg.src];
    take_top  = can_take && pres_live && pres_reg.level == LVL_TOP;
    // Transfers outrank maskable requests but are held off by mask 7
    take_dma  = can_take && !take_top && dma_hit && mask_now != LVL_TOP;
    take_irq  = can_take && !take_dma && pres_live &&
                pres_reg.level >= mask_now;                         // RL6
  end

  // Clears from vector read and from transfer start
  always_comb begin
    clr_vec = '0;
    if (take_irq)
      clr_vec[pres_reg.src] = 1'b1;                                 // RL10
    if (take_dma && !dma_soft)
      clr_vec[dma_src] = 1'b1;
    pend_next = (pend_reg & ~clr_vec) | set_vec;                    // RL21
  end

  // Pending flags; a new event beats a clear in the same cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      pend_reg <= '0;
    else
      pend_reg <= pend_next;                                        // RL21
  end

  // Software transfer requests, held until started
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      soft_reg <= '0;
    else begin
      for (int c = 0; c < NCH; c++) begin
        if (dma_soft_start[c])
          soft_reg[c] <= 1'b1;                                      // RL20
        else if (take_dma && dma_soft && dma_ch == 2'(c))
          soft_reg[c] <= 1'b0;
      end
    end
  end

  // Transfer start pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      dma_reg <= '0;
    else begin
      dma_reg.go      <= take_dma;                                  // RL20
      dma_reg.channel <= dma_ch;
      dma_reg.size    <= dma_size_cfg[dma_ch];
    end
  end

  // Acceptance sequencer; the core executes nothing while in sequence
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      cur_lvl_reg <= LVL_OFF;
      cur_vec_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
          if (take_irq) begin
            cur_lvl_reg <= pres_reg.level;
            cur_vec_reg <= pres_reg.vector;                         // RL10
            state_reg   <= ST_SEQ;
          end
        end
        ST_SEQ: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == SEQ_LAST)
            state_reg <= ST_FIRST;                                  // RL15
        end
        // Hold off sampling until the first handler instruction ends
        ST_FIRST: begin
          if (instr_boundary)
            state_reg <= ST_IDLE;                                   // RL17
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Busy flag mirrors the sequencer being out of idle, set and cleared on the same edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      busy_reg <= 1'b0;
    else
      busy_reg <= take_irq || (state_reg == ST_SEQ) ||
                  (state_reg == ST_FIRST && !instr_boundary);
  end

  // Context pushes: program counter then status word below the pointer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      stack_reg <= '0;
    else begin
      stack_reg.we <= 1'b0;
      if (state_reg == ST_SEQ && cnt_reg == SEQ_PUSH_PC) begin
        stack_reg.we   <= 1'b1;                                     // RL11
        stack_reg.addr <= system_stack_pointer - PC_SLOT;
        stack_reg.data <= core_pc;
      end else if (state_reg == ST_SEQ && cnt_reg == SEQ_PUSH_SR) begin
        stack_reg.we   <= 1'b1;                                     // RL11
        stack_reg.addr <= system_stack_pointer - SR_SLOT;
        stack_reg.data <= {16'h0000, with_mask(status_word, mask_reg)};
      end
    end
  end

  // Interrupt mask; sequence step has priority over instruction writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      mask_reg <= LVL_TOP;                                          // RL18
    else if (state_reg == ST_SEQ && cnt_reg == SEQ_MASK) begin
      if (cur_lvl_reg == LVL_TOP)
        mask_reg <= LVL_TOP;                                        // RL12
      else
        mask_reg <= cur_lvl_reg + LVL_ONE;                          // RL12
    end else if (return_from_handler)
      mask_reg <= popped_status[MASK_LSB +: 3];                     // RL16
    else
      mask_reg <= mask_now;                                         // RL7
  end

  // Nesting count; wraps are the core's concern, zero is not decremented
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      nest_reg <= '0;
    else if (state_reg == ST_SEQ && cnt_reg == SEQ_MASK)
      nest_reg <= nest_reg + NEST_ONE;                              // RL13
    else if (return_from_handler && nest_reg != '0)
      nest_reg <= nest_reg - NEST_ONE;                              // RL16
  end

  // Handler fetch address inside the 256-byte vector area
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fetch_reg <= 1'b0;
      haddr_reg <= VEC_BASE;
    end else begin
      fetch_reg <= (state_reg == ST_SEQ) && (cnt_reg == SEQ_LAST);  // RL15
      if (state_reg == ST_SEQ && cnt_reg == SEQ_LAST)
        haddr_reg <= VEC_BASE + (24'(cur_vec_reg) & (VEC_AREA - 24'h1)); // RL14 RL19
    end
  end

  // Outputs, all from flops
  assign present              = pres_reg;
  assign interrupt_mask_level = mask_reg;
  assign nesting_count        = nest_reg;
  assign accept_busy          = busy_reg;
  assign stack_wr             = stack_reg;
  assign handler_fetch        = fetch_reg;
  assign handler_addr         = haddr_reg;
  assign dma_go               = dma_reg;

endmodule // irq_accept

// ---- test/irq_accept_assertions.sv ----
// Concurrent checks on the ports of the interrupt acceptance block.
// Assumes one clock domain with the block's async active-low reset.
`timescale 1ns/1ps

module irq_accept_assertions
  import irq_accept_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Core events and context
  input wire logic        instr_boundary,
  input wire logic        return_from_handler,
  input wire logic [23:0] system_stack_pointer,
  input wire logic [31:0] core_pc,
  // Block outputs
  input wire present_s    present,
  input wire logic [2:0]  interrupt_mask_level,
  input wire logic [7:0]  nesting_count,
  input wire logic        accept_busy,
  input wire stack_wr_s   stack_wr,
  input wire logic        handler_fetch,
  input wire logic [23:0] handler_addr,
  input wire dma_s        dma_go
);
  logic [2:0] lvl_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Level on offer at each free boundary; frozen while busy, so it is the taken one
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lvl_reg <= LVL_OFF;
    end else if (instr_boundary && !accept_busy) begin
      lvl_reg <= present.level;
    end
  end

  property p_seq_len;
    $rose(accept_busy) |-> ##17 handler_fetch;
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("handler fetch off its slot");

  property p_vec_addr;
    handler_fetch |-> handler_addr[23:8] == VEC_BASE[23:8] && handler_addr[1:0] == 2'h0;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("handler address outside table");

  property p_push_pc;
    $rose(accept_busy) |-> ##3 stack_wr.we && stack_wr.addr == system_stack_pointer - PC_SLOT &&
                           stack_wr.data == $past(core_pc);
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("counter push missing");

  property p_push_sr;
    // Core moves its pointer while this push stands, so compare to the value before
    $rose(accept_busy) |-> ##7 stack_wr.we && stack_wr.addr == $past(system_stack_pointer) - SR_SLOT &&
                           stack_wr.data[MASK_LSB +: 3] == $past(interrupt_mask_level);
  endproperty
  a_push_sr: assert property (p_push_sr) else $error("status push missing");

  property p_mask_step;
    $rose(accept_busy) |-> ##11 interrupt_mask_level == (lvl_reg == LVL_TOP ? LVL_TOP : 3'(lvl_reg + LVL_ONE));
  endproperty
  a_mask_step: assert property (p_mask_step) else $error("mask not level plus one");

  property p_nest_up;
    $rose(accept_busy) |-> ##11 nesting_count == $past(nesting_count, 11) + NEST_ONE;
  endproperty
  a_nest_up: assert property (p_nest_up) else $error("nesting not raised");

  property p_reset_val;
    !$past(reset_n) |-> interrupt_mask_level == LVL_TOP && nesting_count == START_OFF;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad state after reset");

  property p_busy_end;
    $fell(accept_busy) |-> $past(instr_boundary) || $past(instr_boundary, 2);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ended off a boundary");

  property p_nmi_top;
    present.valid && present.src < 6'(NNMI) |-> present.level == LVL_TOP;
  endproperty
  a_nmi_top: assert property (p_nmi_top) else $error("non-maskable not at top level");

  property p_xfer;
    dma_go.go |-> (dma_go.size != 2'h3) ##1 !dma_go.go;
  endproperty
  a_xfer: assert property (p_xfer) else $error("bad transfer start");

  property p_ret;
    return_from_handler && !accept_busy && nesting_count != START_OFF |=> nesting_count == $past(nesting_count) - NEST_ONE;
  endproperty
  a_ret: assert property (p_ret) else $error("nesting not lowered on return");
endmodule // irq_accept_assertions

bind irq_accept irq_accept_assertions i_chk (
  .clock, .reset_n, .instr_boundary, .return_from_handler, .system_stack_pointer, .core_pc, .present,
  .interrupt_mask_level, .nesting_count, .accept_busy, .stack_wr, .handler_fetch, .handler_addr, .dma_go
);

// ---- test/core_model.sv ----
// Behavioural core: paces instruction boundaries and owns the stack pointer.
// Assumes the block's sequence outputs are registered on the same clock.
`timescale 1ns/1ps

module core_model
  import irq_accept_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Cycles per instruction, 2 or more
  input  wire logic [3:0]  gap,
  // Sequence outputs of the block
  input  wire logic        accept_busy,
  input  wire stack_wr_s   stack_wr,
  input  wire logic        handler_fetch,
  // Core side
  output logic             instr_boundary = 1'b0,
  output logic [23:0]      system_stack_pointer = 24'h001000,
  output logic [31:0]      core_pc = 32'h00000100,
  output logic [15:0]      status_word = 16'h0000
);
  logic [3:0] cnt = 4'h0;
  logic       run = 1'b0;

  // No instruction ends during the entry sequence; the handler resumes after fetch
  always @(negedge clock) begin
    instr_boundary = 1'b0;
    if (reset_n) begin
      if (handler_fetch) begin
        run = 1'b1;
      end
      if (!accept_busy) begin
        run = 1'b0;
      end
      cnt = cnt + 4'h1;
      if (cnt >= gap && (!accept_busy || run)) begin
        instr_boundary = 1'b1;
        cnt = 4'h0;
        core_pc = core_pc + 32'h2;
      end
      // Pointer moves past both pushed words once the last push lands
      if (stack_wr.we && stack_wr.addr == system_stack_pointer - SR_SLOT) begin
        system_stack_pointer = stack_wr.addr;
      end
    end
  end
endmodule // core_model

// ---- test/testbench.sv ----
// Self-checking bench for the interrupt acceptance block.
// Assumes core_model paces instructions; bench inputs change on falling edges.
`timescale 1ns/1ps

`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, ac); end end

module testbench
  import irq_accept_pkg::*;
;
  // Stimulus
  logic                 clock = 1'b0, reset_n = 1'b0;
  logic [NCPU-1:0]      cpu_req = '0;
  logic [NPER-1:0]      periph_req = '0;
  logic [NPIN-1:0]      pin_req = '0;
  logic [NMSK-1:0][2:0] level_cfg = '0;
  logic                 set_mask_instruction = 1'b0, mask_all_instruction = 1'b0, return_from_handler = 1'b0;
  logic [2:0]           mask_operand = 3'h0;
  logic [15:0]          popped_status = 16'h0000, status_word;
  logic [NCH-1:0][7:0]  dma_start_vector = '0;
  logic [NCH-1:0][1:0]  dma_size_cfg = '0;
  logic [NCH-1:0]       dma_soft_start = '0;
  logic [3:0]           gap = 4'h3;
  // Core and block outputs
  logic                 instr_boundary, accept_busy, handler_fetch;
  logic [23:0]          system_stack_pointer, handler_addr;
  logic [31:0]          core_pc;
  logic [2:0]           interrupt_mask_level;
  logic [7:0]           nesting_count;
  present_s             present;
  stack_wr_s            stack_wr;
  dma_s                 dma_go;
  int                   errors = 0, compares = 0;

  // 200 MHz system clock
  always #2.5 clock = ~clock;

  irq_accept i_dut (
    .clock, .reset_n, .cpu_req, .periph_req, .pin_req, .level_cfg, .instr_boundary, .set_mask_instruction,
    .mask_all_instruction, .mask_operand, .return_from_handler, .popped_status, .system_stack_pointer,
    .core_pc, .status_word, .dma_start_vector, .dma_size_cfg, .dma_soft_start, .present,
    .interrupt_mask_level, .nesting_count, .accept_busy, .stack_wr, .handler_fetch, .handler_addr, .dma_go
  );

  core_model i_core (
    .clock, .reset_n, .gap, .accept_busy, .stack_wr, .handler_fetch, .instr_boundary,
    .system_stack_pointer, .core_pc, .status_word
  );

  task automatic stop_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic sig(int w);
    case (w)
      0: return accept_busy;
      1: return handler_fetch;
      2: return dma_go.go;
      default: return !accept_busy;
    endcase
  endfunction

  // Bounded wait; a hang shows as a failed compare, not a stall
  task automatic wait_on(int w);
    for (int i = 0; i < 300 && sig(w) !== 1'b1; i++) begin
      @(negedge clock);
    end
    `CHK("wait", 1'b1, sig(w))
  endtask

  task automatic pulse(logic [NCPU-1:0] c, logic [NPER-1:0] p);
    @(negedge clock);
    cpu_req = c;
    periph_req = p;
    @(negedge clock);
    cpu_req = '0;
    periph_req = '0;
  endtask

  // One-cycle core events: 0 set mask, 1 mask all, 2 return, else soft start
  task automatic evt(int w, logic [2:0] a);
    @(negedge clock);
    case (w)
      0: begin
        mask_operand = a;
        set_mask_instruction = 1'b1;
      end
      1: mask_all_instruction = 1'b1;
      2: begin
        popped_status = {1'b0, a, 12'h000};
        return_from_handler = 1'b1;
      end
      default: dma_soft_start = 4'h1 << a;
    endcase
    @(negedge clock);
    {set_mask_instruction, mask_all_instruction, return_from_handler} = 3'h0;
    dma_soft_start = '0;
  endtask

  task automatic accept(logic [7:0] v, logic [2:0] m, logic [7:0] n);
    wait_on(0);
    wait_on(1);
    `CHK("handler_addr", VEC_BASE + {16'h0000, v}, handler_addr)
    `CHK("mask", m, interrupt_mask_level)
    `CHK("nesting", n, nesting_count)
    wait_on(3);
  endtask

  // Watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    stop_test();
  end

  initial begin
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    `CHK("mask_rst", LVL_TOP, interrupt_mask_level)
    `CHK("present_rst", 1'b0, present.valid)
    level_cfg[3] = 3'h3;
    pulse('0, 21'h000002);
    repeat (20) @(negedge clock);
    `CHK("held", present_s'{1'b1, 3'h3, 8'h4c, 6'h0e}, present)
    `CHK("refused", 1'b0, accept_busy)
    evt(0, 3'h3);
    accept(8'h4c, 3'h4, 8'h01);
    `CHK("cleared", 1'b0, present.valid)
    evt(1, 3'h0);
    @(negedge clock);
    `CHK("mask_all", LVL_TOP, interrupt_mask_level)
    level_cfg[4] = 3'h4;
    level_cfg[3] = 3'h4;
    pulse('0, 21'h000006);
    repeat (3) @(negedge clock);
    `CHK("tie", present_s'{1'b1, 3'h4, 8'h4c, 6'h0e}, present)
    pulse(9'h030, '0);
    // Look before the next boundary can take the top request
    @(negedge clock);
    `CHK("nmi", present_s'{1'b1, 3'h7, 8'h0c, 6'h04}, present)
    accept(8'h0c, 3'h7, 8'h02);
    accept(8'h10, 3'h7, 8'h03);
    evt(2, 3'h7);
    @(negedge clock);
    `CHK("ret_nest", 8'h02, nesting_count)
    evt(2, 3'h4);
    @(negedge clock);
    `CHK("ret_mask", 3'h4, interrupt_mask_level)
    accept(8'h4c, 3'h5, 8'h02);
    gap = 4'h9;
    repeat (10) @(negedge clock);
    `CHK("below_mask", present_s'{1'b1, 3'h4, 8'h50, 6'h0f}, present)
    for (int k = 0; k < 3; k++) begin
      dma_size_cfg[k] = 2'(k);
      evt(3, 3'(k));
      wait_on(2);
      `CHK("soft_go", dma_s'{1'b1, 2'(k), 2'(k)}, dma_go)
    end
    dma_size_cfg[3] = 2'h1;
    dma_start_vector[3] = 8'h14;
    // Let the last soft start pulse pass first
    @(negedge clock);
    wait_on(2);
    `CHK("hw_go", dma_s'{1'b1, 2'h3, 2'h1}, dma_go)
    repeat (3) @(negedge clock);
    `CHK("xfer_clear", 1'b0, present.valid)
    // Pin source through the synchroniser and edge detector
    pin_req = 4'h1;
    accept(8'h20, 3'h7, 8'h03);
    stop_test();
  end
endmodule // testbench
